// ### dv/multi_group_pulse_counter_tb.sv
module multi_group_pulse_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rdv, rl, seed = 32'hB684;
    logic o_pready, o_pslverr, erv;
    logic [7:0] i_ext_in, o_cmp_out;
    logic [5:0] o_irq_req;
    logic [47:0] o_irq_label;
    int checks = 0, n_mismatch = 0, hits = 0, base, n, chan[6] = '{0, 2, 3, 5, 6, 7};
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) hits <= hits + $countones({o_cmp_out, o_irq_req});
    pulse_counter dut (.i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_ext_in, .o_cmp_out, .o_irq_req,
        .o_irq_label);
    pulse_source src (.i_clk_sys, .o_ext_in(i_ext_in));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] ga(int g, logic [3:0] w);
        return 12'(g * 64) + {6'h00, w, 2'b00};
    endfunction
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        i_psel <= 1'b1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        rdv = o_prdata;
        erv = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge i_clk_sys);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        apb(ga(1, hsc_pkg::W_NEXT), 1'b0, 32'h0);
        chk(rdv, 32'h1);
        apb(ga(1, hsc_pkg::W_CUR), 1'b1, 32'h5);
        apb(ga(1, hsc_pkg::W_CUR), 1'b0, 32'h0);
        chk(rdv, 32'h1);
        apb(12'h03C, 1'b0, 32'h0);
        chk({31'h0, erv}, 32'h1);
        apb(hsc_pkg::ADDR_CTRL, 1'b1, 32'h3F00);
        foreach (chan[g]) begin
            seed = lfsr(seed);
            rl = {1'b0, seed[30:0]};
            n = int'(seed[0]) + 1;
            base = hits;
            apb(ga(g + 1, hsc_pkg::W_RELOAD), 1'b1, rl);
            apb(ga(g + 1, hsc_pkg::W_PRESET1), 1'b1, rl + 32'(n));
            apb(ga(g + 1, hsc_pkg::W_ACTION), 1'b1, {8'h0, 8'hA0 | 8'(g), 5'h0, 3'(g), 7'h0, g == 5});
            apb(hsc_pkg::ADDR_CLEAR, 1'b1, 32'h1 << g);
            src.pulses(chan[g], n);
            apb(ga(g + 1, hsc_pkg::W_VALUE), 1'b0, 32'h0);
            chk(rdv, rl + 32'(n));
            chk(32'(hits - base), 32'h1);
            apb(ga(g + 1, hsc_pkg::W_ACT_LO), 1'b0, 32'h0);
            chk(rdv, {16'h0, rl[15:0] + 16'(n)});
        end
        chk({24'h0, o_irq_label[47:40]}, 32'hA5);
        $display("test single_phase done");
        apb(hsc_pkg::ADDR_CTRL, 1'b1, 32'h3F01);
        apb(ga(5, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        rl = rdv;
        src.pulses(6, 1);
        apb(ga(5, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, rl);
        apb(hsc_pkg::ADDR_CTRL, 1'b1, 32'h3F10);
        apb(ga(1, hsc_pkg::W_RELOAD), 1'b1, 32'h0);
        apb(hsc_pkg::ADDR_CLEAR, 1'b1, 32'h1);
        apb(hsc_pkg::ADDR_EVENTS, 1'b1, 32'h10101);
        src.pulses(0, 1);
        apb(ga(1, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, 32'hFFFFFFFF);
        src.lvl(1, 1'b1);
        src.pulses(0, 1);
        apb(hsc_pkg::ADDR_EVENTS, 1'b0, 32'h0);
        chk(rdv & 32'h10101, 32'h10100);
        $display("test up_down done");
        apb(ga(3, hsc_pkg::W_RELOAD), 1'b1, 32'h0);
        apb(hsc_pkg::ADDR_CLEAR, 1'b1, 32'h4);
        apb(hsc_pkg::ADDR_CTRL, 1'b1, 32'h3F84);
        src.quad(3, 4, 1'b1);
        apb(ga(3, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, 32'h2);
        apb(hsc_pkg::ADDR_CTRL, 1'b1, 32'h3FC4);
        src.quad(3, 8, 1'b0);
        apb(ga(3, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, 32'hFFFFFFFA);
        apb(ga(4, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        rl = rdv;
        src.pulses(5, 1);
        apb(ga(3, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, 32'h0);
        apb(ga(4, hsc_pkg::W_VALUE), 1'b0, 32'h0);
        chk(rdv, rl);
        $display("test quadrature done");
        for (int p = 0; p < 3; p++)
            apb(ga(2, hsc_pkg::W_PRESET1) + 12'(4 * p), 1'b1, 32'(p + 1));
        apb(ga(2, hsc_pkg::W_RELOAD), 1'b1, 32'h0);
        apb(hsc_pkg::ADDR_CLEAR, 1'b1, 32'h2);
        apb(ga(2, hsc_pkg::W_NPRE), 1'b1, 32'h3);
        base = hits;
        src.pulses(2, 3);
        chk(32'(hits - base), 32'h3);
        apb(ga(2, hsc_pkg::W_NEXT), 1'b0, 32'h0);
        chk(rdv, 32'h2);
        $display("test preset_rotation done");
        complete_run();
    end
endmodule

// ### dv/pulse_counter_sva.sv
module pulse_counter_sva (
    // Watched ports
    input wire logic i_clk_sys, i_reset_n, i_psel, i_penable, i_pwrite,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready, o_pslverr,
    input wire logic [7:0] i_ext_in,
    input wire logic [7:0] o_cmp_out,
    input wire logic [5:0] o_irq_req,
    input wire logic [47:0] o_irq_label
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    wire acc = i_psel && i_penable;
    ready_now_a: assert property (acc |-> o_pready) else $error("no ready");
    err_phase_a: assert property (o_pslverr |-> acc) else $error("stray error");
    err_zero_a: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
        else $error("refused read not zero");
    rd_hold_a: assert property (acc |=> $stable(o_prdata)) else $error("read data moved");
    lbl_hold_a: assert property (!$past(acc && i_pwrite, 2) |-> $stable(o_irq_label))
        else $error("label changed without write");
    cmp_once_a: assert property (o_cmp_out[0] |=> !o_cmp_out[0]) else $error("long pulse");
    irq_once_a: assert property ($rose(o_irq_req[5]) |=> !o_irq_req[5]) else $error("long irq");
    // Events need a pin change a few cycles earlier; reload must not fire them
    ev_cause_a: assert property (|{o_cmp_out, o_irq_req} |-> $past(i_ext_in, 3) != $past(i_ext_in, 6))
        else $error("event without input");
    rst_quiet_a: assert property (disable iff (1'b0) !i_reset_n |=> !(|{o_cmp_out, o_irq_req}))
        else $error("event in reset");
    cover property (o_cmp_out[2]);
    cover property (o_irq_req[5]);
    cover property (o_pslverr);
endmodule

bind pulse_counter pulse_counter_sva u_sva (.i_clk_sys, .i_reset_n, .i_psel, .i_penable,
    .i_pwrite, .o_prdata, .o_pready, .o_pslverr, .i_ext_in, .o_cmp_out, .o_irq_req, .o_irq_label);

// ### dv/pulse_source.sv
module pulse_source (
    // Clock and pulse lines
    input wire logic i_clk_sys,
    output logic [7:0] o_ext_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_ext_in = 8'h00;
    // Half period 500 cycles keeps single-phase lines at 100 kHz
    task automatic lvl(input int c, input logic v);
        o_ext_in[c] <= v;
        repeat (500) @(posedge i_clk_sys);
    endtask
    task automatic pulses(input int c, input int n);
        repeat (n) begin
            lvl(c, 1'b1);
            lvl(c, 1'b0);
        end
    endtask
    // Phase order sets direction; 2000 cycles per edge suits the slowest limit
    task automatic quad(input int a, input int n, input logic up);
        repeat (n) begin
            if (o_ext_in[a] ^ o_ext_in[a + 1] ^ up)
                o_ext_in[a] <= !o_ext_in[a];
            else
                o_ext_in[a + 1] <= !o_ext_in[a + 1];
            repeat (2000) @(posedge i_clk_sys);
        end
    endtask
endmodule

// ### hdl/group_counter.sv
module group_counter (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Count requests
    input wire hsc_pkg::drive_s i_drive,
    input wire logic [31:0] i_reload_value,
    input wire logic [31:0] i_target,
    // Results
    output logic [31:0] o_value,
    output logic o_hit,
    output logic o_ovf,
    output logic o_unf
);

    logic [31:0] value;
    logic [31:0] next_value;
    logic hit;
    logic next_hit;
    logic ovf;
    logic next_ovf;
    logic unf;
    logic next_unf;

    // ------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------
    always_comb begin
        next_value = value;
        next_hit = 1'b0;
        next_ovf = 1'b0;
        next_unf = 1'b0;
        if (i_drive.clear) begin
            next_value = i_reload_value; // (RULE8) (RULE9)
        end else if (i_drive.step) begin
            if (i_drive.down) begin
                next_unf = (value == 32'h0); // (RULE24)
                next_value = value - 32'h1; // (RULE6)
            end else begin
                next_ovf = (value == 32'hFFFFFFFF); // (RULE24)
                next_value = value + 32'h1; // (RULE6)
            end
            // Only a real count can meet the target, not a reload
            next_hit = (next_value == i_target); // (RULE7)
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            value <= 32'h0;
            hit <= 1'b0;
            ovf <= 1'b0;
            unf <= 1'b0;
        end else begin
            value <= next_value;
            hit <= next_hit;
            ovf <= next_ovf;
            unf <= next_unf;
        end
    end

    assign o_value = value;
    assign o_hit = hit;
    assign o_ovf = ovf;
    assign o_unf = unf;

endmodule

// ### hdl/hsc_pkg.sv
package hsc_pkg;

    // ------------
    // Sizes
    // ------------
    localparam int N_GRP = 6;
    localparam int N_IN = 8;
    localparam int N_PRE = 6;

    // ------------
    // Register map (byte addresses, word offsets in a group block)
    // ------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CLEAR = 12'h004;
    localparam logic [11:0] ADDR_EVENTS = 12'h008;
    localparam logic [3:0] W_VALUE = 4'h0;
    localparam logic [3:0] W_RELOAD = 4'h1;
    localparam logic [3:0] W_NPRE = 4'h2;
    localparam logic [3:0] W_NEXT = 4'h3;
    localparam logic [3:0] W_CUR = 4'h4;
    localparam logic [3:0] W_ACT_HI = 4'h5;
    localparam logic [3:0] W_ACT_LO = 4'h6;
    localparam logic [3:0] W_ACTION = 4'h7;
    localparam logic [3:0] W_PRESET1 = 4'h8;
    localparam logic [3:0] W_PRESET6 = 4'hD;

    // ------------
    // Field positions
    // ------------
    localparam int CTRL_SMALL = 0;
    localparam int CTRL_ZCLR1 = 1;
    localparam int CTRL_ZCLR3 = 2;
    localparam int CTRL_MODE1 = 4;
    localparam int CTRL_MODE3 = 6;
    localparam int CTRL_GATE = 8;
    localparam int EV_MATCH = 0;
    localparam int EV_OVF = 8;
    localparam int EV_UNF = 16;
    localparam int ACT_IRQ = 0;
    localparam int ACT_OUT = 8;
    localparam int ACT_LABEL = 16;

    // ------------
    // Reset values and preset number range
    // ------------
    localparam logic [2:0] NPRE_RESET = 3'h1;
    localparam logic [2:0] PRE_NUM_FIRST = 3'h1;
    localparam logic [2:0] PRE_NUM_LAST = 3'h6;

    // ------------
    // Types
    // ------------
    typedef enum logic [1:0] {MODE_ADD, MODE_UPDOWN, MODE_QUAD2, MODE_QUAD4} count_mode_e;

    typedef struct packed {
        logic small_io;
        logic zclr1;
        logic zclr3;
        count_mode_e mode1;
        count_mode_e mode3;
        logic [5:0] gate;
    } ctrl_s;

    typedef struct packed {
        logic to_irq;
        logic [2:0] out_num;
        logic [7:0] label;
    } action_s;

    typedef struct packed {
        logic step;
        logic down;
        logic clear;
    } drive_s;

endpackage

// ### hdl/pulse_counter.sv
// How it works
// (RULE1) Pulses: g1 in0, g2 in2, g3 in3, g4-g6 in5-in7; dir in1, in4.
// (RULE2) Small-I/O option: in6, in7 never count.
// (RULE3) Direction inputs matter only in up/down mode.
// (RULE4) Quadrature: g1 A=in0 B=in1, g3 A=in3 B=in4.
// (RULE5) Z clear on in2/in5 disables group 2/4.
// (RULE6) Values are unsigned 32-bit.
// (RULE7) Match, overflow or underflow fires the action.
// (RULE8) Groups 1, 3 reload by clear bit or Z input.
// (RULE9) Groups 2, 4-6 count up; reload by clear bit only.
// (RULE10) Adding: up on each rising edge.
// (RULE11) Up/down: rising edge, up if direction high.
// (RULE12) 2-edge: count on B edges, up when A leads.
// (RULE13) 4-edge: count on all A and B edges.
// (RULE14) Single-phase sources: 100 kHz, g3 up/down 50 kHz.
// (RULE15) Quadrature: g1 50/25 kHz, g3 25/12.5 kHz.
// (RULE16) One to six presets; one is reused.
// (RULE17) Each match advances the preset, wrapping to one.
// (RULE18) Active preset reads as two 16-bit words.
// (RULE19) Software may rewrite the next preset number.
// (RULE20) Action: output number or interrupt label.
// (RULE21) Match: one-cycle flag, current takes next, next+1.
// (RULE22) Current number read-only; next, presets writable.
// (RULE23) One preset: next number reads one.
// (RULE24) Count wraps both ways, flagging each.
// (RULE25) Inputs synchronised; double phase change gives no count.
module pulse_counter (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // External pulse inputs
    input wire logic [7:0] i_ext_in,
    // Comparison actions
    output logic [7:0] o_cmp_out,
    output logic [5:0] o_irq_req,
    output logic [47:0] o_irq_label
);

    localparam int NG = hsc_pkg::N_GRP;

    // ------------
    // Input synchroniser and edge history
    // ------------
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] hist;
    logic [7:0] rise;

    // sync_a feeds sync_b only; edges come from sync_b against hist
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
            hist <= 8'h00;
        end else begin
            sync_a <= i_ext_in; // (RULE25)
            sync_b <= sync_a;
            hist <= sync_b;
        end
    end

    genvar b;
    generate
        for (b = 0; b < hsc_pkg::N_IN; b++) begin : g_edge
            assign rise[b] = sync_b[b] & ~hist[b];
        end
    endgenerate

    // Returns {step, down}; a double change is a glitch and counts nothing
    function automatic logic [1:0] quad(input logic [1:0] prev, input logic [1:0] cur,
                                        input logic four);
        logic [1:0] chg;
        logic st;
        chg = prev ^ cur;
        st = four ? (chg == 2'b01 || chg == 2'b10) : (chg == 2'b01); // (RULE12) (RULE13) (RULE25)
        quad = {st, st & (prev[1] ^ cur[0])};
    endfunction

    // ------------
    // Control registers
    // ------------
    hsc_pkg::ctrl_s ctrl;
    hsc_pkg::ctrl_s next_ctrl;
    logic wr;
    logic rd_setup;
    logic [2:0] wgrp;
    logic [3:0] woff;
    logic [NG-1:0] sw_clear;

    assign wr = i_psel & i_penable & i_pwrite;
    assign rd_setup = i_psel & ~i_penable;
    assign wgrp = i_paddr[8:6];
    assign woff = i_paddr[5:2];

    always_comb begin
        next_ctrl = ctrl;
        if (wr && i_paddr == hsc_pkg::ADDR_CTRL) begin
            next_ctrl.small_io = i_pwdata[hsc_pkg::CTRL_SMALL];
            next_ctrl.zclr1 = i_pwdata[hsc_pkg::CTRL_ZCLR1];
            next_ctrl.zclr3 = i_pwdata[hsc_pkg::CTRL_ZCLR3];
            next_ctrl.mode1 = hsc_pkg::count_mode_e'(i_pwdata[hsc_pkg::CTRL_MODE1 +: 2]);
            next_ctrl.mode3 = hsc_pkg::count_mode_e'(i_pwdata[hsc_pkg::CTRL_MODE3 +: 2]);
            next_ctrl.gate = i_pwdata[hsc_pkg::CTRL_GATE +: 6];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Clear bits act in the access cycle and never hold
    assign sw_clear = (wr && i_paddr == hsc_pkg::ADDR_CLEAR) ? i_pwdata[5:0] : 6'h00;

    // ------------
    // Input routing per group
    // ------------
    hsc_pkg::drive_s drive [NG];
    logic [1:0] q1;
    logic [1:0] q3;

    assign q1 = quad({hist[0], hist[1]}, {sync_b[0], sync_b[1]},
                     ctrl.mode1 == hsc_pkg::MODE_QUAD4); // (RULE4)
    assign q3 = quad({hist[3], hist[4]}, {sync_b[3], sync_b[4]},
                     ctrl.mode3 == hsc_pkg::MODE_QUAD4); // (RULE4)

    always_comb begin
        for (int g = 0; g < NG; g++) begin
            drive[g] = '0;
            drive[g].clear = sw_clear[g]; // (RULE9)
        end
        // Group 1
        case (ctrl.mode1)
            hsc_pkg::MODE_ADD: drive[0].step = rise[0]; // (RULE1) (RULE10)
            hsc_pkg::MODE_UPDOWN: begin
                drive[0].step = rise[0]; // (RULE11)
                drive[0].down = ~sync_b[1]; // (RULE3)
            end
            default: begin
                drive[0].step = q1[1];
                drive[0].down = q1[0];
            end
        endcase
        // Group 3
        case (ctrl.mode3)
            hsc_pkg::MODE_ADD: drive[2].step = rise[3]; // (RULE1) (RULE10)
            hsc_pkg::MODE_UPDOWN: begin
                drive[2].step = rise[3]; // (RULE11)
                drive[2].down = ~sync_b[4]; // (RULE3)
            end
            default: begin
                drive[2].step = q3[1];
                drive[2].down = q3[0];
            end
        endcase
        drive[0].clear = sw_clear[0] | (ctrl.zclr1 & rise[2]); // (RULE8)
        drive[2].clear = sw_clear[2] | (ctrl.zclr3 & rise[5]); // (RULE8)
        drive[1].step = rise[2] & ~ctrl.zclr1; // (RULE5) (RULE9)
        drive[3].step = rise[5] & ~ctrl.zclr3; // (RULE5) (RULE9)
        drive[4].step = rise[6] & ~ctrl.small_io; // (RULE2)
        drive[5].step = rise[7] & ~ctrl.small_io; // (RULE2)
        for (int g = 0; g < NG; g++) begin
            drive[g].step = drive[g].step & ctrl.gate[g];
        end
    end

    // ------------
    // Per-group counters, presets and sequencing
    // ------------
    logic [31:0] value [NG];
    logic [31:0] reload [NG];
    logic [31:0] preset [NG][hsc_pkg::N_PRE];
    logic [31:0] active [NG];
    logic [2:0] npre [NG];
    logic [2:0] cur_num [NG];
    logic [2:0] nxt_num [NG];
    hsc_pkg::action_s action [NG];
    logic [NG-1:0] hit;
    logic [NG-1:0] ovf;
    logic [NG-1:0] unf;

    genvar gi;
    generate
        for (gi = 0; gi < NG; gi++) begin : g_grp
            logic sel;
            logic [31:0] next_reload;
            logic [31:0] next_preset [hsc_pkg::N_PRE];
            logic [31:0] next_active;
            logic [2:0] next_npre;
            logic [2:0] next_cur;
            logic [2:0] next_nxt;
            hsc_pkg::action_s next_action;
            logic fire;

            assign sel = wr && i_paddr[11:9] == 3'h0 && wgrp == 3'(gi + 1);
            // Overflow and underflow fire the same action as a match
            assign fire = hit[gi] | ovf[gi] | unf[gi]; // (RULE7)

            group_counter u_cnt (
                .i_clk_sys(i_clk_sys),
                .i_reset_n(i_reset_n),
                .i_drive(drive[gi]),
                .i_reload_value(reload[gi]),
                .i_target(active[gi]),
                .o_value(value[gi]),
                .o_hit(hit[gi]),
                .o_ovf(ovf[gi]),
                .o_unf(unf[gi])
            );

            always_comb begin
                next_reload = reload[gi];
                next_npre = npre[gi];
                next_cur = cur_num[gi];
                next_nxt = nxt_num[gi];
                next_active = active[gi];
                next_action = action[gi];
                for (int k = 0; k < hsc_pkg::N_PRE; k++) begin
                    next_preset[k] = preset[gi][k];
                    if (sel && woff == hsc_pkg::W_PRESET1 + 4'(k)) begin
                        next_preset[k] = i_pwdata; // (RULE22)
                    end
                end
                if (sel && woff == hsc_pkg::W_RELOAD) begin
                    next_reload = i_pwdata;
                end
                if (sel && woff == hsc_pkg::W_ACTION) begin
                    next_action.to_irq = i_pwdata[hsc_pkg::ACT_IRQ]; // (RULE20)
                    next_action.out_num = i_pwdata[hsc_pkg::ACT_OUT +: 3];
                    next_action.label = i_pwdata[hsc_pkg::ACT_LABEL +: 8];
                end
                if (sel && woff == hsc_pkg::W_NPRE) begin
                    // New preset count restarts the sequence at preset one
                    if (i_pwdata[2:0] == 3'h0) begin
                        next_npre = hsc_pkg::PRE_NUM_FIRST;
                    end else if (i_pwdata[2:0] > hsc_pkg::PRE_NUM_LAST) begin
                        next_npre = hsc_pkg::PRE_NUM_LAST;
                    end else begin
                        next_npre = i_pwdata[2:0]; // (RULE16)
                    end
                    next_cur = hsc_pkg::PRE_NUM_FIRST;
                    next_nxt = (next_npre > 3'h1) ? 3'h2 : hsc_pkg::PRE_NUM_FIRST; // (RULE23)
                    next_active = preset[gi][0];
                end else if (hit[gi]) begin
                    next_cur = nxt_num[gi]; // (RULE21)
                    next_active = preset[gi][nxt_num[gi] - 3'h1]; // (RULE17)
                    if (nxt_num[gi] >= npre[gi]) begin
                        next_nxt = hsc_pkg::PRE_NUM_FIRST; // (RULE17) (RULE23)
                    end else begin
                        next_nxt = nxt_num[gi] + 3'h1; // (RULE21)
                    end
                end else begin
                    if (sel && woff == hsc_pkg::W_NEXT && npre[gi] > 3'h1
                        && i_pwdata[2:0] != 3'h0 && i_pwdata[2:0] <= npre[gi]) begin
                        next_nxt = i_pwdata[2:0]; // (RULE19)
                    end
                    // Rewriting the live preset updates the running compare
                    for (int k = 0; k < hsc_pkg::N_PRE; k++) begin
                        if (sel && woff == hsc_pkg::W_PRESET1 + 4'(k)
                            && cur_num[gi] == 3'(k + 1)) begin
                            next_active = i_pwdata; // (RULE16)
                        end
                    end
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n) begin
                    reload[gi] <= 32'h0;
                    npre[gi] <= hsc_pkg::NPRE_RESET;
                    cur_num[gi] <= hsc_pkg::PRE_NUM_FIRST;
                    nxt_num[gi] <= hsc_pkg::PRE_NUM_FIRST;
                    active[gi] <= 32'h0;
                    action[gi] <= '0;
                    for (int k = 0; k < hsc_pkg::N_PRE; k++) begin
                        preset[gi][k] <= 32'h0;
                    end
                end else begin
                    reload[gi] <= next_reload;
                    npre[gi] <= next_npre;
                    cur_num[gi] <= next_cur;
                    nxt_num[gi] <= next_nxt;
                    active[gi] <= next_active;
                    action[gi] <= next_action;
                    for (int k = 0; k < hsc_pkg::N_PRE; k++) begin
                        preset[gi][k] <= next_preset[k];
                    end
                end
            end

            // One-cycle interrupt request and its label
            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n) begin
                    o_irq_req[gi] <= 1'b0;
                    o_irq_label[gi*8 +: 8] <= 8'h00;
                end else begin
                    o_irq_req[gi] <= fire & action[gi].to_irq; // (RULE20)
                    o_irq_label[gi*8 +: 8] <= action[gi].label;
                end
            end
        end
    endgenerate

    // ------------
    // Comparison outputs and sticky event flags
    // ------------
    logic [7:0] next_cmp_out;
    logic [31:0] events;
    logic [31:0] next_events;

    always_comb begin
        next_cmp_out = 8'h00;
        for (int g = 0; g < NG; g++) begin
            if ((hit[g] | ovf[g] | unf[g]) && !action[g].to_irq) begin
                next_cmp_out[action[g].out_num] = 1'b1; // (RULE7) (RULE21)
            end
        end
    end

    always_comb begin
        next_events = events;
        if (wr && i_paddr == hsc_pkg::ADDR_EVENTS) begin
            next_events = events & ~i_pwdata;
        end
        // Set after clear so a same-cycle event is never lost
        next_events[hsc_pkg::EV_MATCH +: 6] = next_events[hsc_pkg::EV_MATCH +: 6] | hit;
        next_events[hsc_pkg::EV_OVF +: 6] = next_events[hsc_pkg::EV_OVF +: 6] | ovf; // (RULE24)
        next_events[hsc_pkg::EV_UNF +: 6] = next_events[hsc_pkg::EV_UNF +: 6] | unf; // (RULE24)
        next_events[7:6] = 2'h0;
        next_events[15:14] = 2'h0;
        next_events[31:22] = 10'h000;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_cmp_out <= 8'h00;
            events <= 32'h0;
        end else begin
            o_cmp_out <= next_cmp_out;
            events <= next_events;
        end
    end

    // ------------
    // APB read path
    // ------------
    logic [31:0] rd_word;
    logic mapped;
    logic [31:0] next_prdata;
    logic [2:0] ridx;

    assign ridx = wgrp - 3'h1;

    always_comb begin
        rd_word = 32'h0;
        mapped = 1'b0;
        if (i_paddr[11:9] == 3'h0 && wgrp == 3'h0) begin
            mapped = (woff <= 4'h2);
            if (i_paddr[5:2] == hsc_pkg::ADDR_CTRL[5:2]) begin
                rd_word[hsc_pkg::CTRL_SMALL] = ctrl.small_io;
                rd_word[hsc_pkg::CTRL_ZCLR1] = ctrl.zclr1;
                rd_word[hsc_pkg::CTRL_ZCLR3] = ctrl.zclr3;
                rd_word[hsc_pkg::CTRL_MODE1 +: 2] = ctrl.mode1;
                rd_word[hsc_pkg::CTRL_MODE3 +: 2] = ctrl.mode3;
                rd_word[hsc_pkg::CTRL_GATE +: 6] = ctrl.gate;
            end else if (i_paddr[5:2] == hsc_pkg::ADDR_EVENTS[5:2]) begin
                rd_word = events;
            end
        end else if (i_paddr[11:9] == 3'h0 && wgrp != 3'h7) begin
            mapped = (woff <= hsc_pkg::W_PRESET6);
            case (woff)
                hsc_pkg::W_VALUE: rd_word = value[ridx];
                hsc_pkg::W_RELOAD: rd_word = reload[ridx];
                hsc_pkg::W_NPRE: rd_word = {29'h0, npre[ridx]};
                hsc_pkg::W_NEXT: rd_word = {29'h0, nxt_num[ridx]}; // (RULE23)
                hsc_pkg::W_CUR: rd_word = {29'h0, cur_num[ridx]}; // (RULE22)
                hsc_pkg::W_ACT_HI: rd_word = {16'h0, active[ridx][31:16]}; // (RULE18)
                hsc_pkg::W_ACT_LO: rd_word = {16'h0, active[ridx][15:0]}; // (RULE18)
                hsc_pkg::W_ACTION: begin
                    rd_word[hsc_pkg::ACT_IRQ] = action[ridx].to_irq;
                    rd_word[hsc_pkg::ACT_OUT +: 3] = action[ridx].out_num;
                    rd_word[hsc_pkg::ACT_LABEL +: 8] = action[ridx].label;
                end
                default: begin
                    if (mapped) begin
                        rd_word = preset[ridx][3'(woff - hsc_pkg::W_PRESET1)];
                    end
                end
            endcase
        end
    end

    always_comb begin
        next_prdata = o_prdata;
        if (rd_setup) begin
            next_prdata = rd_word;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h0;
        end else begin
            o_prdata <= next_prdata;
        end
    end

    // Zero-wait slave; unmapped words answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

endmodule
